//--- rtl/lfw_pkg.sv
/*
 * Constants, register map and state type shared by the wake-up sequencer files.
 * Assumes a 250 MHz system clock and a free-running low-frequency time-base clock.
 */
package lfw_pkg;
    localparam int SYS_CLK_KHZ = 250_000;
    localparam int TOUT_STEP_MS = 50;
    localparam int TOUT_STEP_CYCLES = TOUT_STEP_MS * SYS_CLK_KHZ;
    localparam int CARRIER_MIN_US = 550;
    localparam int CARRIER_MIN_CYCLES = (CARRIER_MIN_US * SYS_CLK_KHZ + 999) / 1000;
    localparam int ONOFF_MIN_MS = 10;
    localparam int ONOFF_MIN_CYCLES = ONOFF_MIN_MS * SYS_CLK_KHZ;
    localparam logic [5:0] PREAMBLE_MIN_BITS = 6'h04;
    localparam logic [5:0] CORR_MAX_BITS = 6'h28;
    localparam logic [5:0] PATTERN_END_BITS = 6'h14;
    localparam logic [6:0] RCO_CAL_TICKS = 7'h41;
    localparam logic [3:0] PREAMBLE_CODE = 4'h5;
    localparam logic [4:0] ADDR_PAT_FIRST = 5'h05;
    localparam logic [4:0] ADDR_PAT_SECOND = 5'h06;
    localparam logic [4:0] ADDR_TOUT_RATE = 5'h07;
    localparam logic [4:0] ADDR_FALSE_CNT = 5'h0D;
    localparam int TOUT_MSB = 7;
    localparam int TOUT_LSB = 5;
    localparam int RATE_MSB = 4;
    localparam logic [7:0] RST_PAT_FIRST = 8'h69;
    localparam logic [7:0] RST_PAT_SECOND = 8'h96;
    localparam logic [7:0] RST_TOUT_RATE = 8'h3F;
    localparam logic [7:0] RST_FALSE_CNT = 8'h00;

    typedef enum logic [2:0] {
        ST_LISTEN,
        ST_CARRIER,
        ST_CORR,
        ST_WAKE_DLY,
        ST_WAKE
    } lfw_state_e;
endpackage

//--- rtl/lfw_sync3.sv
/*
 * Three-stage synchroniser for an input from outside the system clock domain.
 * The output changes only once the second and third stages agree.
 */
`timescale 1ns/1ns
module lfw_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic level
);
    logic ff1;
    logic ff2;
    logic ff3;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            ff1 <= din;
            ff2 <= ff1;
            ff3 <= ff2;
            if (ff2 == ff3)
                level <= ff3;
        end
    end
endmodule

//--- rtl/lfw_rtc_toggle.sv
/*
 * Time-base domain: flips a toggle on every rising time-base edge.
 * The system domain turns each flip into one tick, so no word crosses domains.
 */
`timescale 1ns/1ns
module lfw_rtc_toggle (
    input wire logic rtc_clk,
    input wire logic rstn,
    output logic toggle
);
    logic rst_ff1;
    logic rtc_rst_n;

    always_ff @(posedge rtc_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_ff1 <= 1'b0;
            rtc_rst_n <= 1'b0;
        end
        else
        begin
            rst_ff1 <= 1'b1;
            rtc_rst_n <= rst_ff1;
        end
    end

    always_ff @(posedge rtc_clk or negedge rtc_rst_n)
    begin
        if (!rtc_rst_n)
            toggle <= 1'b0;
        else
            toggle <= ~toggle;
    end
endmodule

//--- rtl/lfw_wakeup_seq.sv
/*
 * Wake-up sequencer: carrier qualification, preamble and pattern correlation,
 * wake output with host or timeout release, false wake-up counter, and the
 * internal RC oscillator enable and calibration state.
 * Assumes front-end carrier detect and time-base clock arrive asynchronously;
 * host commands and register strobes are synchronous one-cycle pulses.
 */
`timescale 1ns/1ns
module lfw_wakeup_seq
    import lfw_pkg::*;
#(
    parameter int TOUT_STEP_CYC = TOUT_STEP_CYCLES,
    parameter int CAR_MIN_CYC = CARRIER_MIN_CYCLES,
    parameter int ONOFF_CYC = ONOFF_MIN_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic rtc_clk,
    input wire logic carrier_det,
    input wire logic corr_enable,
    input wire logic onoff_mode,
    input wire logic xtal_select,
    input wire logic power_down,
    input wire logic clear_wake_cmd,
    input wire logic trim_osc_cmd,
    input wire logic reg_wr_en,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic wake,
    output logic rco_enable,
    output logic rco_cal_busy,
    output logic rco_cal_ok
);
    logic rst_ff1;
    logic rst_n;
    logic carrier;
    logic rtc_toggle;
    logic toggle_s;
    logic toggle_d;
    lfw_state_e state;
    lfw_state_e next_state;
    logic [7:0] pat_first;
    logic [7:0] pat_second;
    logic [7:0] tout_rate;
    logic [7:0] false_cnt;
    logic [31:0] car_cnt;
    logic [9:0] car_ticks;
    logic [5:0] phase;
    logic [5:0] chips;
    logic [15:0] shreg;
    logic [31:0] step_cnt;
    logic [2:0] steps;
    logic [6:0] cal_cnt;

    // Active-low reset released through two flip-flops.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    lfw_rtc_toggle u_rtc (
        .rtc_clk(rtc_clk),
        .rstn(rstn),
        .toggle(rtc_toggle)
    );

    lfw_sync3 u_sync_tick (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din(rtc_toggle),
        .level(toggle_s)
    );

    lfw_sync3 u_sync_car (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din(carrier_det),
        .level(carrier)
    );

    wire tick = toggle_s ^ toggle_d;
    wire [2:0] tout_code = tout_rate[TOUT_MSB:TOUT_LSB];
    wire [5:0] bitlen = {1'b0, tout_rate[RATE_MSB:0]} + 6'h01;
    wire [5:0] half = (bitlen[5:1] == 5'h00) ? 6'h01 : {1'b0, bitlen[5:1]};
    wire [9:0] car_max_ticks = {bitlen, 4'h0};
    wire [15:0] pattern = {pat_first, pat_second};
    wire car_min_ok = car_cnt >= 32'(CAR_MIN_CYC);
    // A burst is overlong only past 16 bits and, in on/off mode, past 10 ms too.
    wire car_too_long = (car_ticks >= car_max_ticks)
        && (!onoff_mode || car_cnt >= 32'(ONOFF_CYC));
    wire sample = tick && (phase + 6'h01 == bitlen);
    // Chip sampled as carrier level; pattern is shifted in MSB first.
    wire [15:0] shreg_next = {shreg[14:0], carrier};
    wire [5:0] chips_next = chips + 6'h01;
    wire preamble_bad = (chips_next == PREAMBLE_MIN_BITS)
        && (shreg_next[3:0] != PREAMBLE_CODE);
    wire pat_hit = (chips_next >= PATTERN_END_BITS) && (shreg_next == pattern);
    wire corr_fail = preamble_bad || (!pat_hit && chips_next >= CORR_MAX_BITS);
    wire to_dly = (state == ST_CORR) && sample && pat_hit;
    wire in_car = state == ST_CARRIER;
    wire false_ev = (in_car && corr_enable && car_too_long)
        || (state == ST_CORR && sample && corr_fail);
    wire step_done = step_cnt + 32'h1 >= 32'(TOUT_STEP_CYC);
    wire tout_fire = (tout_code != 3'h0) && step_done
        && (steps + 3'h1 == tout_code);
    wire release_ev = (state == ST_WAKE) && (clear_wake_cmd || tout_fire);
    wire rco_off = power_down || xtal_select;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_LISTEN:
                if (carrier)
                    next_state = ST_CARRIER;
            ST_CARRIER:
                if (!corr_enable && car_min_ok)
                    next_state = ST_WAKE;
                else if (corr_enable && car_too_long)
                    next_state = ST_LISTEN;
                else if (!carrier)
                    next_state = (corr_enable && car_min_ok) ? ST_CORR : ST_LISTEN;
            ST_CORR:
                if (sample && corr_fail)
                    next_state = ST_LISTEN;
                else if (sample && pat_hit)
                    next_state = ST_WAKE_DLY;
            ST_WAKE_DLY:
                if (sample && chips == 6'h01)
                    next_state = ST_WAKE;
            ST_WAKE:
                if (release_ev)
                    next_state = ST_LISTEN;
            default:
                next_state = ST_LISTEN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            toggle_d <= 1'b0;
            state <= ST_LISTEN;
            wake <= 1'b0;
        end
        else
        begin
            toggle_d <= toggle_s;
            state <= next_state;
            wake <= next_state == ST_WAKE;
        end
    end

    // Carrier length is tracked both in cycles and in time-base ticks.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            car_cnt <= 32'h0;
            car_ticks <= 10'h000;
        end
        else if (!in_car)
        begin
            car_cnt <= 32'h0;
            car_ticks <= 10'h000;
        end
        else
        begin
            car_cnt <= car_cnt + 32'h1;
            car_ticks <= car_ticks + {9'h000, tick};
        end
    end

    // First sample half a bit after the carrier drops, then one per bit.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= 6'h00;
            chips <= 6'h00;
            shreg <= 16'h0000;
        end
        else if (state == ST_CARRIER)
        begin
            phase <= bitlen - half;
            chips <= 6'h00;
            shreg <= 16'h0000;
        end
        else if (tick)
        begin
            // The match is seen mid-chip, so the bit clock is moved to chip edges first.
            phase <= !sample ? phase + 6'h01 : to_dly ? half : 6'h00;
            if (sample && (state == ST_CORR || state == ST_WAKE_DLY))
            begin
                chips <= to_dly ? 6'h00 : chips_next;
                shreg <= shreg_next;
            end
        end
    end

    // Timeout counts from the wake rise; any exit clears it.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_cnt <= 32'h0;
            steps <= 3'h0;
        end
        else if (!wake || release_ev)
        begin
            step_cnt <= 32'h0;
            steps <= 3'h0;
        end
        else if (step_done)
        begin
            step_cnt <= 32'h0;
            steps <= steps + 3'h1;
        end
        else
            step_cnt <= step_cnt + 32'h1;
    end

    // The counter wraps after 255; software compares successive reads.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pat_first <= RST_PAT_FIRST;
            pat_second <= RST_PAT_SECOND;
            tout_rate <= RST_TOUT_RATE;
            false_cnt <= RST_FALSE_CNT;
        end
        else
        begin
            if (reg_wr_en && reg_addr == ADDR_PAT_FIRST)
                pat_first <= reg_wdata;
            if (reg_wr_en && reg_addr == ADDR_PAT_SECOND)
                pat_second <= reg_wdata;
            if (reg_wr_en && reg_addr == ADDR_TOUT_RATE)
                tout_rate <= reg_wdata;
            if (false_ev)
                false_cnt <= false_cnt + 8'h01;
        end
    end

    wire [7:0] rd_mux = (reg_addr == ADDR_PAT_FIRST) ? pat_first
        : (reg_addr == ADDR_PAT_SECOND) ? pat_second
        : (reg_addr == ADDR_TOUT_RATE) ? tout_rate
        : (reg_addr == ADDR_FALSE_CNT) ? false_cnt : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rd_mux;
    end

    // Trim is held only in flops, so stopping the oscillator forgets it.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rco_enable <= 1'b0;
            rco_cal_busy <= 1'b0;
            rco_cal_ok <= 1'b0;
            cal_cnt <= 7'h00;
        end
        else if (rco_off)
        begin
            rco_enable <= 1'b0;
            rco_cal_busy <= 1'b0;
            rco_cal_ok <= 1'b0;
            cal_cnt <= 7'h00;
        end
        else
        begin
            rco_enable <= 1'b1;
            if (trim_osc_cmd)
            begin
                rco_cal_busy <= 1'b1;
                rco_cal_ok <= 1'b0;
                cal_cnt <= 7'h00;
            end
            else if (rco_cal_busy && tick)
            begin
                cal_cnt <= cal_cnt + 7'h01;
                if (cal_cnt + 7'h01 == RCO_CAL_TICKS)
                begin
                    rco_cal_busy <= 1'b0;
                    rco_cal_ok <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_release_cmd;
        (state == ST_WAKE && clear_wake_cmd) |=> !wake && state == ST_LISTEN;
    endproperty
    a_release_cmd: assert property (p_release_cmd) else $error("wake held after release");

    property p_tout_fire;
        (wake && tout_code != 3'h0 && steps + 3'h1 == tout_code && step_done) |=> !wake;
    endproperty
    a_tout_fire: assert property (p_tout_fire) else $error("timeout kept wake");

    property p_tout_zero;
        (state == ST_WAKE && tout_code == 3'h0 && !clear_wake_cmd) |=> wake;
    endproperty
    a_tout_zero: assert property (p_tout_zero) else $error("code 000 released wake");

    property p_start_clear;
        $rose(wake) |-> steps == 3'h0 && step_cnt == 32'h0;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("stale timeout at rise");

    property p_exit_clear;
        release_ev |=> step_cnt == 32'h0 && steps == 3'h0 && !wake;
    endproperty
    a_exit_clear: assert property (p_exit_clear) else $error("timeout left after exit");

    property p_carrier_only;
        (in_car && !corr_enable && car_min_ok) |=> wake;
    endproperty
    a_carrier_only: assert property (p_carrier_only) else $error("no wake on carrier");

    property p_false_inc;
        false_ev |=> false_cnt == $past(false_cnt) + 8'h01;
    endproperty
    a_false_inc: assert property (p_false_inc) else $error("false count not bumped");

    property p_overlong;
        (in_car && corr_enable && car_too_long) |=> state == ST_LISTEN && !wake;
    endproperty
    a_overlong: assert property (p_overlong) else $error("overlong burst kept");

    property p_onoff_floor;
        (in_car && corr_enable && onoff_mode && car_cnt < 32'(ONOFF_CYC)) |-> !false_ev;
    endproperty
    a_onoff_floor: assert property (p_onoff_floor) else $error("on/off burst cut early");

    property p_wake_rise;
        $rose(wake) |-> $past(state) == ST_WAKE_DLY || $past(state) == ST_CARRIER;
    endproperty
    a_wake_rise: assert property (p_wake_rise) else $error("wake rose from bad state");

    property p_phase_range;
        state == ST_CORR |-> phase < bitlen;
    endproperty
    a_phase_range: assert property (p_phase_range) else $error("phase past bit length");

    property p_rco_off;
        rco_off |=> !rco_enable && !rco_cal_ok && !rco_cal_busy;
    endproperty
    a_rco_off: assert property (p_rco_off) else $error("oscillator kept on");

    property p_cal_start;
        (trim_osc_cmd && !rco_off) |=> rco_cal_busy && !rco_cal_ok;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration not started");
endmodule

//--- sim/lfw_tx_model.sv
/*
 * Transmitter model: a carrier burst, then an optional 0101 preamble and a 16-chip pattern.
 * Assumes a free-running time-base clock; chips change on its rising edge.
 */
`timescale 1ns/1ns
module lfw_tx_model (
    input wire logic rtc_clk,
    input wire logic go,
    input wire logic [7:0] car_ticks,
    input wire logic with_pat,
    input wire logic [5:0] bitlen,
    input wire logic [15:0] pattern,
    output logic carrier_det,
    output logic busy
);
    int i;

    initial
    begin
        carrier_det = 1'b0;
        busy = 1'b0;
    end

    // The detector line idles low between frames, since no carrier is present then.
    always @(posedge go)
    begin
        busy = 1'b1;
        @(posedge rtc_clk);
        carrier_det <= 1'b1;
        repeat (car_ticks) @(posedge rtc_clk);
        if (with_pat)
        begin
            for (i = 0; i < 20; i++)
            begin
                carrier_det <= (i < 4) ? i[0] : pattern[19 - i];
                repeat (bitlen) @(posedge rtc_clk);
            end
        end
        carrier_det <= 1'b0;
        busy = 1'b0;
    end
endmodule

//--- sim/test_lfw_wakeup_seq.sv
/*
 * Self-checking bench for the wake-up sequencer, driving it through a transmitter model.
 * Assumes lfw_pkg and the design files are compiled first.
 */
`timescale 1ns/1ns
module test_lfw_wakeup_seq;
    import lfw_pkg::*;
    typedef struct {int kind; logic [15:0] exp; string name;} lfw_note_s;
    logic sys_clk, rstn, rtc_clk, carrier_det, corr_enable, onoff_mode, xtal_select;
    logic power_down, clear_wake_cmd, trim_osc_cmd, reg_wr_en, wake, rco_enable;
    logic rco_cal_busy, rco_cal_ok, go, with_pat, busy;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cnt, car_ticks;
    logic [5:0] bitlen;
    logic [15:0] pattern, pv, hi_len, last_len;
    lfw_note_s q[$];
    int fails, n_tests;
    event look;

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        rtc_clk = 1'b0;
        #7;
        forever #32 rtc_clk = ~rtc_clk;
    end

    lfw_wakeup_seq #(.TOUT_STEP_CYC(20), .CAR_MIN_CYC(8), .ONOFF_CYC(2000)) dut (
        .sys_clk, .rstn, .rtc_clk, .carrier_det, .corr_enable, .onoff_mode, .xtal_select,
        .power_down, .clear_wake_cmd, .trim_osc_cmd, .reg_wr_en, .reg_addr, .reg_wdata,
        .reg_rdata, .wake, .rco_enable, .rco_cal_busy, .rco_cal_ok
    );

    lfw_tx_model tx (
        .rtc_clk, .go, .car_ticks, .with_pat, .bitlen, .pattern, .carrier_det, .busy
    );

    // Length of the last wake pulse in system cycles.
    always @(posedge sys_clk)
    begin
        if (wake === 1'b1)
            hi_len <= hi_len + 16'h0001;
        else
        begin
            if (hi_len != 16'h0000)
                last_len <= hi_len;
            hi_len <= 16'h0000;
        end
    end

    always @(look)
    begin
        lfw_note_s e;
        logic [15:0] obs;
        e = q.pop_front();
        case (e.kind)
            0: obs = {8'h00, reg_rdata};
            1: obs = {15'h0000, wake};
            2: obs = {15'h0000, rco_enable};
            3: obs = {15'h0000, rco_cal_busy};
            4: obs = {15'h0000, rco_cal_ok};
            default: obs = last_len;
        endcase
        n_tests++;
        if (obs !== e.exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", e.name, e.exp, obs);
        end
    end

    task automatic note(input int kind, input logic [15:0] exp, input string name);
        q.push_back('{kind, exp, name});
        @(negedge sys_clk);
        -> look;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] d, input string n);
        @(posedge sys_clk);
        reg_addr <= a;
        @(posedge sys_clk);
        note(0, {8'h00, d}, n);
    endtask

    task automatic pulse(input int trim);
        @(posedge sys_clk);
        if (trim == 0)
            clear_wake_cmd <= 1'b1;
        else
            trim_osc_cmd <= 1'b1;
        @(posedge sys_clk);
        clear_wake_cmd <= 1'b0;
        trim_osc_cmd <= 1'b0;
    endtask

    task automatic wait_wake(input logic v, input int lim);
        for (int k = 0; k < lim && wake !== v; k++)
            @(posedge sys_clk);
    endtask

    task automatic send(input logic [7:0] t, input logic p, input logic [15:0] pat);
        @(posedge sys_clk);
        car_ticks <= t;
        with_pat <= p;
        pattern <= pat;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        for (int k = 0; k < 20000 && busy; k++)
            @(posedge sys_clk);
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        results();
    end

    initial
    begin
        {rstn, corr_enable, onoff_mode, xtal_select, power_down} = 5'h00;
        {clear_wake_cmd, trim_osc_cmd, reg_wr_en, go, with_pat} = 5'h00;
        {reg_addr, reg_wdata, car_ticks, pattern, pv} = '0;
        {hi_len, last_len, cnt} = '0;
        bitlen = 6'h04;
        fails = 0;
        n_tests = 0;
        void'($urandom(32'hAB4D));
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(ADDR_PAT_FIRST, RST_PAT_FIRST, "pattern byte 1");
        rd(ADDR_PAT_SECOND, RST_PAT_SECOND, "pattern byte 2");
        rd(ADDR_TOUT_RATE, RST_TOUT_RATE, "timeout/rate");
        wr(ADDR_FALSE_CNT, 8'h5A);
        rd(ADDR_FALSE_CNT, 8'h00, "false count");
        wr(5'h1F, 8'hA5);
        rd(5'h1F, 8'h00, "unmapped");
        wr(ADDR_TOUT_RATE, 8'h03);
        rd(ADDR_TOUT_RATE, 8'h03, "rate readback");
        $display("test registers done");
        send(8'h01, 1'b0, 16'h0000);
        wait_wake(1'b1, 100);
        note(1, 16'h0001, "wake on carrier");
        repeat (300) @(posedge sys_clk);
        note(1, 16'h0001, "wake held, code 0");
        pulse(0);
        note(1, 16'h0000, "wake after release");
        for (int c = 1; c < 8; c++)
        begin
            wr(ADDR_TOUT_RATE, {c[2:0], 5'h03});
            send(8'h01, 1'b0, 16'h0000);
            wait_wake(1'b0, 400);
            repeat (2) @(posedge sys_clk);
            note(5, 16'(c * 20), "wake length");
        end
        wr(ADDR_TOUT_RATE, 8'h03);
        $display("test release done");
        // Bit 0 of the pattern is set so zeros shifted in after it never match again.
        pv = 16'($urandom()) | 16'h0001;
        wr(ADDR_PAT_FIRST, pv[15:8]);
        wr(ADDR_PAT_SECOND, pv[7:0]);
        @(posedge sys_clk);
        corr_enable <= 1'b1;
        send(8'h0A, 1'b1, pv);
        note(1, 16'h0000, "wake at pattern end");
        repeat (48) @(posedge sys_clk);
        note(1, 16'h0000, "wake before one bit");
        wait_wake(1'b1, 96);
        note(1, 16'h0001, "wake after pattern");
        pulse(0);
        send(8'h0A, 1'b1, pv ^ 16'h8000);
        repeat (2000) @(posedge sys_clk);
        note(1, 16'h0000, "wake on bad pattern");
        cnt = cnt + 8'h01;
        rd(ADDR_FALSE_CNT, cnt, "count after bad pattern");
        // A held carrier re-qualifies after the overlong drop and then fails its preamble.
        send(8'd70, 1'b0, 16'h0000);
        repeat (3000) @(posedge sys_clk);
        cnt = cnt + 8'h02;
        rd(ADDR_FALSE_CNT, cnt, "count after long burst");
        @(posedge sys_clk);
        onoff_mode <= 1'b1;
        send(8'd70, 1'b1, pv);
        wait_wake(1'b1, 96);
        note(1, 16'h0001, "wake after on/off burst");
        pulse(0);
        @(posedge sys_clk);
        onoff_mode <= 1'b0;
        corr_enable <= 1'b0;
        $display("test correlation done");
        pulse(1);
        @(posedge sys_clk);
        note(3, 16'h0001, "calibration busy");
        for (int k = 0; k < 1500 && rco_cal_ok !== 1'b1; k++)
            @(posedge sys_clk);
        note(4, 16'h0001, "calibration ok");
        @(posedge sys_clk);
        xtal_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        note(2, 16'h0000, "rc off on crystal");
        note(4, 16'h0000, "calibration lost");
        pulse(1);
        @(posedge sys_clk);
        note(3, 16'h0000, "trim while off");
        @(posedge sys_clk);
        xtal_select <= 1'b0;
        repeat (4) @(posedge sys_clk);
        note(2, 16'h0000 | 16'h0001, "rc on");
        note(4, 16'h0000, "calibration stays lost");
        @(posedge sys_clk);
        power_down <= 1'b1;
        repeat (4) @(posedge sys_clk);
        note(2, 16'h0000, "rc off in power-down");
        $display("test time base done");
        results();
    end
endmodule
